// >>> logic/pmc_regs.vh
`ifndef PMC_REGS_VH
`define PMC_REGS_VH
// Register byte addresses on the AXI4-Lite slave
`define PMC_ADDR_CTRL_ONE   4'h0
`define PMC_ADDR_CTRL_TWO   4'h4
`define PMC_ADDR_STATUS     4'h8
// Control one fields
`define PMC_C1_STBY         7
`define PMC_C1_STS_HI       6
`define PMC_C1_STS_LO       4
`define PMC_C1_LSPD         3
`define PMC_C1_RSVD         8'h07
`define PMC_C1_WMASK        8'hF8
// Control two fields
`define PMC_C2_NFR          4
`define PMC_C2_DIRECT       3
`define PMC_C2_MSPD         2
`define PMC_C2_SUB_HI       1
`define PMC_C2_SUB_LO       0
`define PMC_C2_RSVD         8'hE0
`define PMC_C2_WMASK        8'h1F
// Reset values of the writable bits
`define PMC_C1_RESET        8'h00
`define PMC_C2_RESET        8'h00
// Operating modes
`define PMC_MODE_HIGH       3'h0
`define PMC_MODE_MED        3'h1
`define PMC_MODE_SUB        3'h2
`define PMC_MODE_SLEEP      3'h3
`define PMC_MODE_STBY       3'h4
`define PMC_MODE_WATCH      3'h5
`define PMC_MODE_SUBSLP     3'h6
// Divider terminal counts
`define PMC_NF_DIV16        5'h0F
`define PMC_NF_DIV4         5'h03
`define PMC_SUB_DIV8        3'h7
`define PMC_SUB_DIV4        3'h3
`define PMC_SUB_DIV2        3'h1
// AXI responses
`define PMC_RESP_OKAY       2'h0
`define PMC_RESP_SLVERR     2'h2
`endif

// >>> logic/pmc_clk_div.v
`timescale 1ns/1ps
// Programmable tick divider, one pulse per terminal count
module pmc_clk_div #(
  parameter W = 5
) (
  // Clock and control
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         ce,
  input  wire         run,
  // Terminal count and output tick
  input  wire [W-1:0] term,
  output reg          tick
);
  reg [W-1:0] cnt_r;

  // Count up to term then tick and wrap
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= {W{1'b0}};
        tick  <= 1'b0;
      end else if (cnt_r >= term) begin
        cnt_r <= {W{1'b0}};
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        tick  <= 1'b0;
      end
    end
  end
endmodule // pmc_clk_div

// >>> logic/pmc_settle.v
`timescale 1ns/1ps
// Oscillator settling timer, counts the selected number of states
module pmc_settle #(
  parameter BASE = 8192
) (
  // Clock and control
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  input  wire       start,
  input  wire [2:0] sel,
  // Settling finished pulse
  output reg        done
);
  reg [17:0] cnt_r;
  reg        busy_r;
  reg [17:0] len;

  // Length decode, top bit set selects the longest
  always @* begin
    if (sel[2])
      len = BASE[17:0] << 4;
    else
      len = BASE[17:0] << sel[1:0];
  end

  // Count states after start
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= 18'h00000;
      busy_r <= 1'b0;
      done   <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r  <= len - 18'h00001;
      end else if (busy_r) begin
        if (cnt_r == 18'h00000) begin
          busy_r <= 1'b0;
          done   <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 18'h00001;
        end
      end
    end
  end
endmodule // pmc_settle

// >>> logic/pmc_top.v
`timescale 1ns/1ps
`include "pmc_regs.vh"
module pmc_top #(
  parameter SETTLE_BASE = 8192
) (
  // Clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // CPU side
  input  wire        sleep_req,
  input  wire        int_mask,
  input  wire        timer_watch_bit,
  output reg         cpu_halt,
  output reg         exc_start,
  // Wake sources, already gated by their enables
  input  wire        wake_timer_a,
  input  wire        wake_timer_other,
  input  wire [1:0]  wake_ext_irq_lo,
  input  wire [2:0]  wake_ext_irq_hi,
  input  wire [7:0]  wake_pin,
  input  wire        wake_serial,
  input  wire        wake_adc,
  // Clock and peripheral control
  output reg  [2:0]  mode,
  output reg         use_subclock,
  output reg         osc_run,
  output reg         clk_gate,
  output reg         pwm_halt,
  output reg         periph_halt,
  output reg         port_float,
  output reg         nf_sample,
  output reg         sub_tick
);
  reg [7:0]  ctl1_r;
  reg [7:0]  ctl2_r;
  reg [2:0]  mode_r;
  reg [2:0]  mode_nxt;
  reg        wait_r;
  reg [2:0]  target_r;
  reg        aw_hold_r;
  reg        w_hold_r;
  reg [3:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  wire       nf_tick;
  wire       sw_tick;
  wire       settle_done;
  reg        settle_go;

  wire stby  = ctl1_r[`PMC_C1_STBY];
  wire lspd  = ctl1_r[`PMC_C1_LSPD];
  wire drct  = ctl2_r[`PMC_C2_DIRECT];
  wire mspd  = ctl2_r[`PMC_C2_MSPD];
  wire is_active = (mode_r == `PMC_MODE_HIGH) || (mode_r == `PMC_MODE_MED);

  // Active mode resume target from the medium bit
  function [2:0] act_mode;
    input m;
    begin
      act_mode = m ? `PMC_MODE_MED : `PMC_MODE_HIGH;
    end
  endfunction

  wire any_pin   = |wake_pin;
  wire wk_stby   = !int_mask && (|wake_ext_irq_lo || any_pin);
  wire wk_watch  = !int_mask && (wake_timer_a || wake_ext_irq_lo[0] || any_pin);
  wire wk_subslp = !int_mask && (wake_timer_a || wake_timer_other || |wake_ext_irq_lo
                   || |wake_ext_irq_hi || any_pin);
  wire wk_sleep  = wk_subslp || (!int_mask && (wake_serial || wake_adc));

  // Mode decision on sleep instruction or wake
  always @* begin
    mode_nxt  = mode_r;
    settle_go = 1'b0;
    case (mode_r)
      `PMC_MODE_HIGH, `PMC_MODE_MED: begin
        if (sleep_req) begin
          if (drct && mode_r == `PMC_MODE_HIGH && !stby && mspd && !lspd)
            mode_nxt = `PMC_MODE_MED;
          else if (drct && mode_r == `PMC_MODE_MED && !stby && !mspd && !lspd)
            mode_nxt = `PMC_MODE_HIGH;
          else if (drct && stby && timer_watch_bit && lspd)
            mode_nxt = `PMC_MODE_SUB;
          else if (!stby && !lspd)
            mode_nxt = `PMC_MODE_SLEEP;
          else if (stby && !lspd && !timer_watch_bit)
            mode_nxt = `PMC_MODE_STBY;
          else if (stby && timer_watch_bit)
            mode_nxt = `PMC_MODE_WATCH;
        end
      end
      `PMC_MODE_SUB: begin
        if (sleep_req) begin
          if (drct && stby && timer_watch_bit && !lspd)
            mode_nxt = act_mode(mspd);
          else if (stby && timer_watch_bit)
            mode_nxt = `PMC_MODE_WATCH;
          else if (!stby && lspd && timer_watch_bit)
            mode_nxt = `PMC_MODE_SUBSLP;
        end
      end
      `PMC_MODE_SLEEP: begin
        if (wk_sleep)
          mode_nxt = act_mode(mspd);
      end
      `PMC_MODE_STBY: begin
        if (wait_r)
          settle_go = 1'b0;
        else if (wk_stby)
          settle_go = 1'b1;
        if (settle_done)
          mode_nxt = target_r;
      end
      `PMC_MODE_WATCH: begin
        if (!wait_r && wk_watch && lspd)
          mode_nxt = `PMC_MODE_SUB;
        else if (!wait_r && wk_watch)
          settle_go = 1'b1;
        if (settle_done)
          mode_nxt = target_r;
      end
      `PMC_MODE_SUBSLP: begin
        if (wk_subslp)
          mode_nxt = `PMC_MODE_SUB;
      end
      default: mode_nxt = `PMC_MODE_HIGH;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_r   <= `PMC_MODE_HIGH;
      wait_r   <= 1'b0;
      target_r <= `PMC_MODE_HIGH;
    end else if (ce) begin
      mode_r <= mode_nxt;
      if (settle_go) begin
        wait_r   <= 1'b1;
        target_r <= act_mode(mspd);
      end else if (settle_done) begin
        wait_r <= 1'b0;
      end
    end
  end

  pmc_settle #(
    .BASE (SETTLE_BASE)
  ) u_settle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .start   (settle_go),
    .sel     (ctl1_r[`PMC_C1_STS_HI:`PMC_C1_STS_LO]),
    .done    (settle_done)
  );

  pmc_clk_div #(
    .W (5)
  ) u_nf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (1'b1),
    .term    (ctl2_r[`PMC_C2_NFR] ? `PMC_NF_DIV4 : `PMC_NF_DIV16),
    .tick    (nf_tick)
  );

  pmc_clk_div #(
    .W (3)
  ) u_sub (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (mode_r == `PMC_MODE_SUB),
    .term    (ctl2_r[`PMC_C2_SUB_HI] ? `PMC_SUB_DIV2 :
              (ctl2_r[`PMC_C2_SUB_LO] ? `PMC_SUB_DIV4 : `PMC_SUB_DIV8)),
    .tick    (sw_tick)
  );

  // Mode dependent outputs and tick samples, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode         <= `PMC_MODE_HIGH;
      use_subclock <= 1'b0;
      osc_run      <= 1'b1;
      clk_gate     <= 1'b0;
      cpu_halt     <= 1'b0;
      exc_start    <= 1'b0;
      pwm_halt     <= 1'b0;
      periph_halt  <= 1'b0;
      port_float   <= 1'b0;
      nf_sample    <= 1'b0;
      sub_tick     <= 1'b0;
    end else if (ce) begin
      mode         <= mode_nxt;
      use_subclock <= (mode_nxt == `PMC_MODE_SUB) || (mode_nxt == `PMC_MODE_SUBSLP);
      osc_run      <= (mode_nxt != `PMC_MODE_STBY) || wait_r || settle_go;
      clk_gate     <= (mode_nxt == `PMC_MODE_STBY) || (mode_nxt == `PMC_MODE_WATCH);
      port_float   <= (mode_nxt == `PMC_MODE_STBY);
      periph_halt  <= (mode_nxt == `PMC_MODE_STBY);
      cpu_halt     <= (mode_nxt == `PMC_MODE_SLEEP) || (mode_nxt == `PMC_MODE_STBY) ||
                      (mode_nxt == `PMC_MODE_WATCH) || (mode_nxt == `PMC_MODE_SUBSLP);
      pwm_halt     <= (mode_nxt == `PMC_MODE_SLEEP) || (mode_nxt == `PMC_MODE_STBY);
      exc_start    <= !is_active && (mode_r != `PMC_MODE_SUB) && (mode_nxt != mode_r);
      nf_sample    <= nf_tick;
      sub_tick     <= sw_tick;
    end
  end

  // Write channel capture, either order
  wire wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PMC_RESP_OKAY;
      ctl1_r        <= `PMC_C1_RESET;
      ctl2_r        <= `PMC_C2_RESET;
    end else if (ce) begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PMC_RESP_OKAY;
        case (awaddr_r)
          `PMC_ADDR_CTRL_ONE: begin
            if (wstrb_r[0])
              ctl1_r <= wdata_r[7:0] & `PMC_C1_WMASK;
          end
          `PMC_ADDR_CTRL_TWO: begin
            if (wstrb_r[0]) begin
              ctl2_r[`PMC_C2_NFR:`PMC_C2_MSPD] <= wdata_r[`PMC_C2_NFR:`PMC_C2_MSPD];
              if (mode_r != `PMC_MODE_SUB)
                ctl2_r[`PMC_C2_SUB_HI:`PMC_C2_SUB_LO] <=
                  wdata_r[`PMC_C2_SUB_HI:`PMC_C2_SUB_LO];
            end
          end
          `PMC_ADDR_STATUS: s_axi_bresp <= `PMC_RESP_OKAY;
          default: s_axi_bresp <= `PMC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel, one outstanding read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PMC_RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `PMC_RESP_OKAY;
        case (s_axi_araddr)
          `PMC_ADDR_CTRL_ONE: s_axi_rdata <= {24'h000000, ctl1_r | `PMC_C1_RSVD};
          `PMC_ADDR_CTRL_TWO: s_axi_rdata <= {24'h000000, ctl2_r | `PMC_C2_RSVD};
          `PMC_ADDR_STATUS:   s_axi_rdata <= {27'h0000000, wait_r, 1'b0, mode_r};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `PMC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // pmc_top

// >>> sim/pmc_asserts.sv
`timescale 1ns/1ps
`include "pmc_regs.vh"
module pmc_asserts (
  // Clock and reset
  input logic       aclk,
  input logic       aresetn,
  input logic       ce,
  // Core and wake inputs
  input logic       sleep_req,
  input logic       int_mask,
  input logic [1:0] wake_ext_irq_lo,
  input logic [7:0] wake_pin,
  input logic       wake_serial,
  input logic       wake_adc,
  // Mode and control outputs
  input logic [2:0] mode,
  input logic       cpu_halt,
  input logic       pwm_halt,
  input logic       periph_halt,
  input logic       port_float,
  input logic       osc_run
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Standby with the oscillator still stopped
  wire stby_dark = (mode == `PMC_MODE_STBY) && !osc_run;
  wire sleeping  = (mode == `PMC_MODE_SLEEP);
  wire active    = (mode == `PMC_MODE_HIGH) || (mode == `PMC_MODE_MED) || (mode == `PMC_MODE_SUB);

  a_reset_clear: assert property ($rose(aresetn) |-> mode == `PMC_MODE_HIGH && !cpu_halt)
    else $error("mode not cleared by reset");
  a_sleep_halt: assert property (sleeping |-> cpu_halt && pwm_halt && !periph_halt)
    else $error("sleep halt outputs wrong");
  a_mask_holds: assert property (sleeping && int_mask |=> sleeping)
    else $error("masked wake left sleep");
  a_sleep_wake: assert property (sleeping && ce && !int_mask && (wake_adc || wake_serial)
    |-> ##[1:3] !sleeping)
    else $error("enabled interrupt did not end sleep");
  a_stby_float: assert property (mode == `PMC_MODE_STBY |-> port_float)
    else $error("ports not floating in standby");
  a_stby_pins: assert property (stby_dark && wake_ext_irq_lo == 2'h0 && wake_pin == 8'h00
    |=> !osc_run)
    else $error("standby woken by wrong source");
  a_settle_first: assert property (stby_dark |=> mode == `PMC_MODE_STBY)
    else $error("standby left without settling");
  a_mode_hold: assert property (active && !sleep_req |=> $stable(mode))
    else $error("mode changed without event");

  c_sleep: cover property (sleeping ##1 !sleeping);
  c_stby: cover property (stby_dark ##1 osc_run);
  c_sub: cover property (mode == `PMC_MODE_SUB);
  c_watch: cover property (mode == `PMC_MODE_WATCH ##1 mode == `PMC_MODE_SUB);
endmodule // pmc_asserts

bind pmc_top pmc_asserts u_chk (.aclk, .aresetn, .ce, .sleep_req, .int_mask, .wake_ext_irq_lo,
  .wake_pin, .wake_serial, .wake_adc, .mode, .cpu_halt, .pwm_halt, .periph_halt, .port_float,
  .osc_run);

// >>> sim/pmc_cpu_model.sv
`timescale 1ns/1ps
module pmc_cpu_model (
  // Clock and reset
  input  logic       aclk,
  input  logic       aresetn,
  // Bench commands
  input  logic       cmd_sleep,
  input  logic       cmd_mask,
  // Controller side
  input  logic       cpu_halt,
  input  logic       exc_start,
  output logic       sleep_req = 1'b0,
  output logic       int_mask  = 1'b0,
  output logic [7:0] exc_count = 8'h00
);
  always @(posedge aclk) begin
    sleep_req <= cmd_sleep & ~cpu_halt & aresetn;
    int_mask  <= cmd_mask;
  end
  always @(posedge aclk) begin
    if (!aresetn)
      exc_count <= 8'h00;
    else if (exc_start)
      exc_count <= exc_count + 8'h01;
  end
endmodule // pmc_cpu_model

// >>> sim/test_power_mode_controller.sv
`timescale 1ns/1ps
`include "pmc_regs.vh"
module test_power_mode_controller;
  localparam int BASE = 4;
  localparam logic [3:0] R1 = `PMC_ADDR_CTRL_ONE;
  localparam logic [3:0] R2 = `PMC_ADDR_CTRL_TWO;
  localparam logic [1:0] OK = `PMC_RESP_OKAY;
  logic        aclk, aresetn, ce, sleep_req, int_mask, timer_watch_bit, cpu_halt, exc_start;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [16:0] wk;
  logic [2:0]  mode;
  logic        use_subclock, osc_run, clk_gate, pwm_halt, periph_halt, port_float;
  logic        nf_sample, sub_tick, cmd_sleep, cmd_mask;
  logic [7:0]  exc_count, v, e;
  int          err_total, comparisons, seed, n, i;

  pmc_top #(.SETTLE_BASE(BASE)) dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_req, .int_mask, .timer_watch_bit,
    .cpu_halt, .exc_start, .wake_timer_a(wk[0]), .wake_timer_other(wk[1]),
    .wake_ext_irq_lo(wk[3:2]), .wake_ext_irq_hi(wk[6:4]), .wake_pin(wk[14:7]),
    .wake_serial(wk[15]), .wake_adc(wk[16]), .mode, .use_subclock, .osc_run, .clk_gate,
    .pwm_halt, .periph_halt, .port_float, .nf_sample, .sub_tick);
  pmc_cpu_model u_cpu (.aclk, .aresetn, .cmd_sleep, .cmd_mask, .cpu_halt, .exc_start,
    .sleep_req, .int_mask, .exc_count);

  // Free-running bench clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Expected register readbacks and settling lengths
  function automatic logic [7:0] c1x(input logic [7:0] d);
    return (d & `PMC_C1_WMASK) | `PMC_C1_RSVD;
  endfunction
  function automatic logic [7:0] c2x(input logic [7:0] d);
    return (d & `PMC_C2_WMASK) | `PMC_C2_RSVD;
  endfunction
  function automatic int settle(input logic [2:0] s);
    return s[2] ? (BASE << 4) : (BASE << s);
  endfunction

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop;
  endtask

  // Single write, address and data offered together
  task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (k == 50) hang;
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] x, input logic [1:0] r);
    int k;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (k == 50) hang;
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, r);
    if (r == OK) chk(s_axi_rdata, x);
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (n = 0; n < lim && mode !== m; n++) @(posedge aclk);
    if (n == lim) hang;
  endtask
  task automatic sleep_op(input logic [2:0] m);
    @(posedge aclk);
    cmd_sleep <= 1'b1;
    @(posedge aclk);
    cmd_sleep <= 1'b0;
    wait_mode(m, 10);
    chk(mode, m);
  endtask
  // Cycles between two ticks, sub divider when s is set
  task automatic gap(input int s);
    for (i = 0; i < 100 && (s ? sub_tick : nf_sample) !== 1'b1; i++) @(posedge aclk);
    @(posedge aclk);
    for (n = 1; n < 100 && (s ? sub_tick : nf_sample) !== 1'b1; n++) @(posedge aclk);
  endtask

  // Main sequence
  initial begin
    seed = 32'ha262;
    err_total = 0;
    comparisons = 0;
    {ce, aresetn, cmd_sleep, cmd_mask, timer_watch_bit, wk} = {2'b10, 20'h0};
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = {8'h00, 4'hF, 32'h0};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(R1, 32'h07, OK);
    axi_rd(R2, 32'hE0, OK);
    for (int j = 0; j < 6; j++) begin
      v = $random(seed);
      axi_wr(j[0] ? R2 : R1, v, OK);
      axi_rd(j[0] ? R2 : R1, j[0] ? c2x(v) : c1x(v), OK);
    end
    axi_wr(4'hC, 8'h00, `PMC_RESP_SLVERR);
    axi_rd(4'hC, 32'h0, `PMC_RESP_SLVERR);
    axi_wr(R2, 8'h00, OK);
    gap(0);
    chk(n, 16);
    axi_wr(R2, 8'h10, OK);
    gap(0);
    chk(n, 4);
    axi_wr(R1, 8'h00, OK);
    axi_wr(R2, 8'h04, OK);
    sleep_op(`PMC_MODE_SLEEP);
    chk({cpu_halt, pwm_halt, periph_halt}, 3'b110);
    e = exc_count;
    cmd_mask <= 1'b1;
    // Mask reaches the controller before any source rises
    repeat (2) @(posedge aclk);
    wk <= 17'h1 << ($unsigned($random(seed)) % 17);
    repeat (20) @(posedge aclk);
    chk(mode, `PMC_MODE_SLEEP);
    cmd_mask <= 1'b0;
    wait_mode(`PMC_MODE_MED, 20);
    repeat (3) @(posedge aclk);
    chk(exc_count, e + 8'h01);
    wk <= 17'h0;
    axi_wr(R2, 8'h08, OK);
    sleep_op(`PMC_MODE_HIGH);
    axi_wr(R2, 8'h0C, OK);
    sleep_op(`PMC_MODE_MED);
    axi_wr(R1, 8'h88, OK);
    timer_watch_bit <= 1'b1;
    sleep_op(`PMC_MODE_SUB);
    chk(use_subclock, 1);
    axi_wr(R2, 8'h0D, OK);
    axi_rd(R2, 32'hEC, OK);
    gap(1);
    chk(n, 8);
    axi_wr(R1, 8'h80, OK);
    sleep_op(`PMC_MODE_MED);
    timer_watch_bit <= 1'b0;
    axi_wr(R2, 8'h00, OK);
    for (int j = 0; j < 6; j++) begin
      v = {1'b1, (j == 5) ? 3'h7 : j[2:0], 4'h0};
      axi_wr(R1, v, OK);
      sleep_op(`PMC_MODE_STBY);
      chk(port_float, 1);
      chk({osc_run, clk_gate}, 2'b01);
      wk <= 17'h18073 & $random(seed);
      repeat (30) @(posedge aclk);
      chk(mode, `PMC_MODE_STBY);
      e = exc_count;
      wk <= 17'h1 << ((j < 2) ? 2 + j : 5 + j);
      wait_mode(`PMC_MODE_HIGH, 200);
      chk(n >= settle(v[6:4]) && n <= settle(v[6:4]) + 4, 1);
      wk <= 17'h0;
      repeat (3) @(posedge aclk);
      chk(exc_count, e + 8'h01);
    end
    // Watch, subactive and subsleep round trip
    axi_wr(R2, 8'h02, OK);
    axi_wr(R1, 8'h88, OK);
    timer_watch_bit <= 1'b1;
    sleep_op(`PMC_MODE_WATCH);
    wk <= 17'h00001;
    wait_mode(`PMC_MODE_SUB, 20);
    wk <= 17'h0;
    gap(1);
    chk(n, 2);
    axi_wr(R1, 8'h08, OK);
    sleep_op(`PMC_MODE_SUBSLP);
    wk <= 17'h00010;
    wait_mode(`PMC_MODE_SUB, 20);
    wk <= 17'h0;
    axi_wr(R1, 8'h80, OK);
    axi_wr(R2, 8'h08, OK);
    sleep_op(`PMC_MODE_HIGH);
    timer_watch_bit <= 1'b0;
    axi_wr(R1, 8'h00, OK);
    sleep_op(`PMC_MODE_SLEEP);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk({mode, cpu_halt}, 4'h0);
    axi_rd(R1, 32'h07, OK);
    report_and_stop;
  end
endmodule // test_power_mode_controller
